// ---- hw/rdd_cfg.svh ----
// Reset distribution constants: timing counts and reset values
`ifndef RDD_CFG_SVH
`define RDD_CFG_SVH
`define RDD_CLK_MHZ          50
`define RDD_PULSE_NS         100
`define RDD_PULSE_CYC        ((`RDD_PULSE_NS * `RDD_CLK_MHZ + 999) / 1000)
`define RDD_NVM_LOAD_NS      200
`define RDD_NVM_LOAD_CYC     ((`RDD_NVM_LOAD_NS * `RDD_CLK_MHZ + 999) / 1000)
`define RDD_CNT_W            4
`define RDD_FIELD_W          16
`define RDD_PG_FIELD_RST     16'h0000
`define RDD_POWER_MGMT_CTRL_STATUS_PME_EN     0
`define RDD_POWER_MGMT_CTRL_STATUS_PME_ST     1
`define RDD_POWER_MGMT_CTRL_STATUS_AUX_EN     2
`define RDD_SRC_N            8
`define RDD_SRC_PWR_GOOD     0
`define RDD_SRC_PIN          1
`define RDD_SRC_INBAND       2
`define RDD_SRC_FW           3
`define RDD_SRC_D3D0         4
`define RDD_SRC_FLR          5
`define RDD_SRC_PORT_SW      6
`define RDD_SRC_DEV_SW       7
`endif

// ---- hw/rdd_pkg.sv ----
// Types for the reset distribution block
package rdd_pkg;
    typedef enum logic [2:0] {
        RDD_NVM_IDLE = 3'b001,
        RDD_NVM_LOAD = 3'b010,
        RDD_NVM_DONE = 3'b100
    } rdd_nvm_st_t;
endpackage

// ---- hw/rdd_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module rdd_sync
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // Data
    input  wire logic async_in,
    output var  logic sync_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Only accept a level once the last two stages agree
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            sync_out <= 1'b0;
        else if (s2_ff == s3_ff)
            sync_out <= s3_ff;
    end
endmodule
`default_nettype wire

// ---- hw/rdd_top.sv ----
// Reset distribution: combines reset sources into per-group resets
`timescale 1ns/100ps
`default_nettype none
`include "rdd_cfg.svh"

// Notes on behaviour
// - Power-good, PCIe pin or in-band reset send link training back to detect.
// - D3hot-D0, FLR, port reset clear datapath, memories, MAC, queues, stats.
// - Memory config cleared by power-good, pin, firmware, D3hot-D0, FLR and port reset.
// - Wake status cleared only by power-good; survives per-function resets.
// - Without aux power, wake context clears so PME enable and status read 0.
// - Pin direction, energy, optics, link mode, VLAN, LED: power-good only.
// - Every NVM read reloads the power-good-only fields from stored values.
// - Aux-power-detected bit cleared only by power-good or PCIe pin.
// - Flash access register cleared by power-good only.
// - Semaphore, tag, sync counters, sync bits: PCIe-local, not per-function.
// - MSI-X control, PBA, masks reset by D3hot-D0 and FLR, not port reset.
// - Wake context shadow copies reset exactly like the originals.
// - Filter tables and ring bases have no default and survive all resets.
// - Transmit data forced to zero during port or device software reset.
// - Tx and Rx packet buffers are cleared when they are reset.
// - NVM and flash request and grant bits cleared by power-good or pin only.
// - DMA control and parity regs cleared by power-good, PCIe, device sw.
// - Device software reset triggers reload of function NVM sections.
// - Port software reset leaves PCIe config and DMA logic alone.
module rdd_top
    import rdd_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Common reset sources
    input  wire logic        power_good_reset,
    input  wire logic        pcie_reset_pin_n,
    input  wire logic        inband_pcie_reset,
    input  wire logic        firmware_reset,
    // Per-function reset sources
    input  wire logic        d3hot_d0_reset,
    input  wire logic        flr_reset,
    input  wire logic        port_software_reset,
    input  wire logic        device_software_reset,
    // Power state and NVM
    input  wire logic        aux_power,
    input  wire logic        nvm_read_strobe,
    input  wire logic [15:0] nvm_pg_fields,
    // Transmit path
    input  wire logic [7:0]  tx_data_in,
    output var  logic [7:0]  tx_data_out,
    // Group resets, active high
    output var  logic        ltssm_reset_ff,
    output var  logic        link_path_reset_ff,
    output var  logic        cfg_nonsticky_reset_ff,
    output var  logic        cfg_sticky_reset_ff,
    output var  logic        pcie_local_reset_ff,
    output var  logic        data_path_reset_ff,
    output var  logic        memory_reset_ff,
    output var  logic        mac_reset_ff,
    output var  logic        dma_reset_ff,
    output var  logic        dma_ctl_parity_reset_ff,
    output var  logic        queue_enable_reset_ff,
    output var  logic        intr_stats_reset_ff,
    output var  logic        msix_reset_ff,
    output var  logic        wake_context_reset_ff,
    output var  logic        wake_ctrl_reset_ff,
    output var  logic        wake_status_reset_ff,
    output var  logic        wake_mgmt_reset_ff,
    output var  logic        mem_cfg_reset_ff,
    output var  logic        strap_reset_ff,
    output var  logic        aux_detect_reset_ff,
    output var  logic        flash_access_reset_ff,
    output var  logic        pg_field_reset_ff,
    output var  logic        pkt_buf_clear_ff,
    // Power-good-only fields and reload requests
    output var  logic [15:0] pg_fields_ff,
    output var  logic        nvm_func_reload_ff,
    // Wake context as seen by software
    output var  logic        pme_enable_ff,
    output var  logic        pme_status_ff,
    output var  logic        wake_shadow_pme_en_ff,
    output var  logic        wake_shadow_pme_st_ff
);
    // Synchronised sources, indexed by the source positions in the header
    logic [`RDD_SRC_N-1:0] src_raw;
    logic [`RDD_SRC_N-1:0] src;
    logic                  any_pg;
    logic                  any_pin;
    logic                  any_inb;
    logic                  any_fw;
    logic                  any_d3;
    logic                  any_flr;
    logic                  any_port;
    logic                  any_dev;
    logic                  any_func;
    rdd_nvm_st_t           nvm_st_ff;
    logic [`RDD_CNT_W-1:0] load_cnt_ff;
    logic                  dev_sw_d_ff;

    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    assign src_raw = {device_software_reset, port_software_reset, flr_reset,
                      d3hot_d0_reset, firmware_reset, inband_pcie_reset,
                      ~pcie_reset_pin_n, power_good_reset};

    // Every source comes from outside this clock's domain
    genvar gi;
    generate
        for (gi = 0; gi < `RDD_SRC_N; gi = gi + 1)
        begin : g_sync
            rdd_sync u_sync
            (
                .sys_clk  (sys_clk),
                .reset    (reset),
                .async_in (src_raw[gi]),
                .sync_out (src[gi])
            );
        end
    endgenerate

    assign any_pg   = src[`RDD_SRC_PWR_GOOD];
    assign any_pin  = src[`RDD_SRC_PIN];
    assign any_inb  = src[`RDD_SRC_INBAND];
    assign any_fw   = src[`RDD_SRC_FW];
    assign any_d3   = src[`RDD_SRC_D3D0];
    assign any_flr  = src[`RDD_SRC_FLR];
    assign any_port = src[`RDD_SRC_PORT_SW];
    assign any_dev  = src[`RDD_SRC_DEV_SW];
    assign any_func = any_d3 | any_flr | any_port;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            ltssm_reset_ff         <= 1'b1;
            link_path_reset_ff     <= 1'b1;
            cfg_nonsticky_reset_ff <= 1'b1;
            cfg_sticky_reset_ff    <= 1'b1;
            pcie_local_reset_ff    <= 1'b1;
        end
        else
        begin
            ltssm_reset_ff         <= any_pg | any_pin | any_inb;
            link_path_reset_ff     <= any_pg | any_pin | any_inb;
            cfg_nonsticky_reset_ff <= any_pg | any_pin | any_d3 | any_flr;
            cfg_sticky_reset_ff    <= any_pg | any_pin | any_inb;
            pcie_local_reset_ff    <= any_pg | any_pin | any_inb;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            data_path_reset_ff    <= 1'b1;
            memory_reset_ff       <= 1'b1;
            mac_reset_ff          <= 1'b1;
            queue_enable_reset_ff <= 1'b1;
            intr_stats_reset_ff   <= 1'b1;
            pkt_buf_clear_ff      <= 1'b1;
        end
        else
        begin
            data_path_reset_ff    <= any_pg | any_pin | any_inb | any_func;
            memory_reset_ff       <= any_pg | any_pin | any_inb | any_func;
            mac_reset_ff          <= any_pg | any_pin | any_inb | any_func;
            queue_enable_reset_ff <= any_pg | any_pin | any_inb | any_func
                                     | any_dev;
            intr_stats_reset_ff   <= any_pg | any_pin | any_inb | any_func;
            pkt_buf_clear_ff      <= any_pg | any_pin | any_inb | any_func;
        end
    end

    // DMA and MSI-X groups
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            dma_reset_ff            <= 1'b1;
            dma_ctl_parity_reset_ff <= 1'b1;
            msix_reset_ff           <= 1'b1;
        end
        else
        begin
            dma_reset_ff            <= any_pg | any_pin | any_inb | any_dev
                                       | any_d3 | any_flr;
            dma_ctl_parity_reset_ff <= any_pg | any_pin | any_inb | any_dev;
            msix_reset_ff           <= any_pg | any_pin | any_inb | any_d3
                                       | any_flr;
        end
    end

    // Wake, configuration, strap and flash groups
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            wake_context_reset_ff <= 1'b1;
            wake_ctrl_reset_ff    <= 1'b1;
            wake_status_reset_ff  <= 1'b1;
            wake_mgmt_reset_ff    <= 1'b1;
            mem_cfg_reset_ff      <= 1'b1;
            strap_reset_ff        <= 1'b1;
            aux_detect_reset_ff   <= 1'b1;
            flash_access_reset_ff <= 1'b1;
            pg_field_reset_ff     <= 1'b1;
        end
        else
        begin
            // pin reset clears wake context only when aux power is off
            wake_context_reset_ff <= any_pg | any_inb
                                     | (~aux_power & any_pin);
            wake_ctrl_reset_ff    <= any_pg | any_inb;
            wake_status_reset_ff  <= any_pg;
            wake_mgmt_reset_ff    <= any_pg | any_pin;
            mem_cfg_reset_ff      <= any_pg | any_pin | any_fw | any_func;
            strap_reset_ff        <= any_pg | any_pin;
            aux_detect_reset_ff   <= any_pg | any_pin;
            flash_access_reset_ff <= any_pg;
            pg_field_reset_ff     <= any_pg;
        end
    end

    // filter tables and ring bases get no reset output at all

    // zero transmit data during software resets
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            tx_data_out <= 8'h00;
        else if (any_port | any_dev)
            tx_data_out <= 8'h00;
        else
            tx_data_out <= tx_data_in;
    end

    // device reset rising edge starts a reload
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            dev_sw_d_ff <= 1'b0;
        else
            dev_sw_d_ff <= any_dev;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            nvm_st_ff          <= RDD_NVM_IDLE;
            load_cnt_ff        <= 4'h0;
            nvm_func_reload_ff <= 1'b0;
        end
        else
        begin
            unique case (nvm_st_ff)
                RDD_NVM_IDLE:
                    if (any_dev & ~dev_sw_d_ff)
                    begin
                        nvm_st_ff          <= RDD_NVM_LOAD;
                        load_cnt_ff <= `RDD_CNT_W'(`RDD_NVM_LOAD_CYC - 1);
                        nvm_func_reload_ff <= 1'b1;
                    end
                RDD_NVM_LOAD:
                    if (load_cnt_ff == 4'h0)
                    begin
                        nvm_st_ff          <= RDD_NVM_DONE;
                        nvm_func_reload_ff <= 1'b0;
                    end
                    else
                        load_cnt_ff <= load_cnt_ff - 4'h1;
                RDD_NVM_DONE:
                    if (~any_dev)
                        nvm_st_ff <= RDD_NVM_IDLE;
            endcase
        end
    end

    // power-good fields cleared; reload on every NVM read
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            pg_fields_ff <= `RDD_PG_FIELD_RST;
        else if (nvm_read_strobe)
            pg_fields_ff <= nvm_pg_fields;
        else if (any_pg)
            pg_fields_ff <= `RDD_PG_FIELD_RST;
    end

    // wake bits and their shadows share one reset term
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pme_enable_ff         <= 1'b0;
            pme_status_ff         <= 1'b0;
            wake_shadow_pme_en_ff <= 1'b0;
            wake_shadow_pme_st_ff <= 1'b0;
        end
        else if (any_pg | any_inb | (~aux_power & any_pin))
        begin
            pme_enable_ff         <= 1'b0;
            pme_status_ff         <= 1'b0;
            wake_shadow_pme_en_ff <= 1'b0;
            wake_shadow_pme_st_ff <= 1'b0;
        end
    end

    // Checks
    // wake status ignores per-function resets
    a_wake_status_pg: assert property (!any_pg |=> !wake_status_reset_ff)
        else $error("wake status reset without power-good");
    // MSI-X not reset by port reset alone
    a_msix_port: assert property (any_port && !(any_pg || any_pin
        || any_inb || any_d3 || any_flr) |=> !msix_reset_ff)
        else $error("port reset touched MSI-X");
    a_tx_zero: assert property ((any_port || any_dev) |=>
        tx_data_out == 8'h00)
        else $error("tx data not zero in software reset");
    a_func_path: assert property (any_flr |=> data_path_reset_ff
        && mac_reset_ff && memory_reset_ff)
        else $error("function reset missed datapath");
    a_ltssm_pin: assert property (any_pin |=> ltssm_reset_ff)
        else $error("pin reset missed link training");
    // DMA parity untouched by FLR alone
    a_dma_parity: assert property (any_flr && !(any_pg || any_pin
        || any_inb || any_dev) |=> !dma_ctl_parity_reset_ff)
        else $error("FLR cleared DMA parity");
    a_nvm_reload: assert property (nvm_read_strobe |=>
        pg_fields_ff == $past(nvm_pg_fields))
        else $error("power-good fields not reloaded");
    // reload pulse lasts the full load count of ten cycles
    a_func_reload: assert property ($rose(nvm_func_reload_ff) |->
        nvm_func_reload_ff[*8] ##1 nvm_func_reload_ff ##1
        nvm_func_reload_ff ##1 !nvm_func_reload_ff)
        else $error("function reload wrong length");
    // flash access only on power-good; skip the edge leaving reset
    a_flash_pg: assert property (flash_access_reset_ff && !$past(reset)
        |-> $past(any_pg))
        else $error("flash access reset without power-good");

    c_flr: cover property ($rose(any_flr));
    c_port: cover property ($rose(any_port));
    c_reload: cover property ($rose(nvm_func_reload_ff));
endmodule
`default_nettype wire

// ---- verif/rdd_host_model.sv ----
// Host and platform reset model driving every source of the block
`timescale 1ns/100ps
`default_nettype none
`include "rdd_cfg.svh"
module rdd_host_model
(
    // Clock
    input  wire logic        sys_clk,
    // Common reset sources
    output var  logic        power_good_reset,
    output var  logic        pcie_reset_pin_n,
    output var  logic        inband_pcie_reset,
    output var  logic        firmware_reset,
    // Per-function reset sources
    output var  logic        d3hot_d0_reset,
    output var  logic        flr_reset,
    output var  logic        port_software_reset,
    output var  logic        device_software_reset,
    // Power state, NVM and transmit data
    output var  logic        aux_power,
    output var  logic        nvm_read_strobe,
    output var  logic [15:0] nvm_pg_fields,
    output var  logic [7:0]  tx_data_in
);
    // One level per source, indexed like the block's source numbering
    logic [`RDD_SRC_N-1:0] src_lvl = '0;

    assign power_good_reset      = src_lvl[`RDD_SRC_PWR_GOOD];
    assign pcie_reset_pin_n      = ~src_lvl[`RDD_SRC_PIN];
    assign inband_pcie_reset     = src_lvl[`RDD_SRC_INBAND];
    assign firmware_reset        = src_lvl[`RDD_SRC_FW];
    assign d3hot_d0_reset        = src_lvl[`RDD_SRC_D3D0];
    assign flr_reset             = src_lvl[`RDD_SRC_FLR];
    assign port_software_reset   = src_lvl[`RDD_SRC_PORT_SW];
    assign device_software_reset = src_lvl[`RDD_SRC_DEV_SW];

    initial
    begin
        aux_power       = 1'b1;
        nvm_read_strobe = 1'b0;
        nvm_pg_fields   = 16'h0000;
        tx_data_in      = 8'h00;
    end

    task automatic set_src(input int idx, input logic lvl);
        @(negedge sys_clk);
        src_lvl[idx] = lvl;
    endtask

    task automatic set_aux(input logic lvl);
        @(negedge sys_clk);
        aux_power = lvl;
    endtask

    task automatic set_tx(input logic [7:0] val);
        @(negedge sys_clk);
        tx_data_in = val;
    endtask

    task automatic nvm_load(input logic [15:0] val);
        @(negedge sys_clk);
        nvm_pg_fields   = val;
        nvm_read_strobe = 1'b1;
        @(negedge sys_clk);
        nvm_read_strobe = 1'b0;
        // Stale data must not be mistaken for a valid load
        nvm_pg_fields   = ~val;
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_reset_domain_distribution.sv ----
// Self-checking bench for the reset distribution block
`timescale 1ns/100ps
`default_nettype none
`include "rdd_cfg.svh"
module tb_reset_domain_distribution;
    localparam int MAX_CYC = 3000;
    localparam int SETTLE  = 8;

    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        power_good_reset, pcie_reset_pin_n, inband_pcie_reset;
    logic        firmware_reset, d3hot_d0_reset, flr_reset;
    logic        port_software_reset, device_software_reset;
    logic        aux_power, nvm_read_strobe;
    logic [15:0] nvm_pg_fields;
    logic [7:0]  tx_data_in, tx_data_out;
    logic        ltssm_reset_ff, link_path_reset_ff, cfg_nonsticky_reset_ff;
    logic        cfg_sticky_reset_ff, pcie_local_reset_ff, data_path_reset_ff;
    logic        memory_reset_ff, mac_reset_ff, dma_reset_ff;
    logic        dma_ctl_parity_reset_ff, queue_enable_reset_ff;
    logic        intr_stats_reset_ff, msix_reset_ff, wake_context_reset_ff;
    logic        wake_ctrl_reset_ff, wake_status_reset_ff, wake_mgmt_reset_ff;
    logic        mem_cfg_reset_ff, strap_reset_ff, aux_detect_reset_ff;
    logic        flash_access_reset_ff, pg_field_reset_ff, pkt_buf_clear_ff;
    logic [15:0] pg_fields_ff;
    logic        nvm_func_reload_ff, pme_enable_ff, pme_status_ff;
    logic        wake_shadow_pme_en_ff, wake_shadow_pme_st_ff;
    logic [22:0] grp;
    int          err_count = 0;
    int          n_tests   = 0;
    int          cyc_count = 0;

    assign grp = {ltssm_reset_ff, link_path_reset_ff, cfg_nonsticky_reset_ff,
        cfg_sticky_reset_ff, pcie_local_reset_ff, data_path_reset_ff,
        memory_reset_ff, mac_reset_ff, dma_reset_ff, dma_ctl_parity_reset_ff,
        queue_enable_reset_ff, intr_stats_reset_ff, msix_reset_ff,
        wake_context_reset_ff, wake_ctrl_reset_ff, wake_status_reset_ff,
        wake_mgmt_reset_ff, mem_cfg_reset_ff, strap_reset_ff,
        aux_detect_reset_ff, flash_access_reset_ff, pg_field_reset_ff,
        pkt_buf_clear_ff};

    rdd_host_model host
    (
        .sys_clk, .power_good_reset, .pcie_reset_pin_n, .inband_pcie_reset,
        .firmware_reset, .d3hot_d0_reset, .flr_reset, .port_software_reset,
        .device_software_reset, .aux_power, .nvm_read_strobe,
        .nvm_pg_fields, .tx_data_in
    );

    rdd_top DUT
    (
        .sys_clk, .reset, .power_good_reset, .pcie_reset_pin_n,
        .inband_pcie_reset, .firmware_reset, .d3hot_d0_reset, .flr_reset,
        .port_software_reset, .device_software_reset, .aux_power,
        .nvm_read_strobe, .nvm_pg_fields, .tx_data_in, .tx_data_out,
        .ltssm_reset_ff, .link_path_reset_ff, .cfg_nonsticky_reset_ff,
        .cfg_sticky_reset_ff, .pcie_local_reset_ff, .data_path_reset_ff,
        .memory_reset_ff, .mac_reset_ff, .dma_reset_ff,
        .dma_ctl_parity_reset_ff, .queue_enable_reset_ff,
        .intr_stats_reset_ff, .msix_reset_ff, .wake_context_reset_ff,
        .wake_ctrl_reset_ff, .wake_status_reset_ff, .wake_mgmt_reset_ff,
        .mem_cfg_reset_ff, .strap_reset_ff, .aux_detect_reset_ff,
        .flash_access_reset_ff, .pg_field_reset_ff, .pkt_buf_clear_ff,
        .pg_fields_ff, .nvm_func_reload_ff, .pme_enable_ff, .pme_status_ff,
        .wake_shadow_pme_en_ff, .wake_shadow_pme_st_ff
    );

    always #10 sys_clk = ~sys_clk;

    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc_count++;
        if (cyc_count == MAX_CYC)
        begin
            err_count++;
            close_out();
        end
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Bits outside care are left open by the reset tables
    task automatic cmp_grp(input string what, input logic [22:0] exp,
                           input logic [22:0] care);
        n_tests++;
        if ((grp & care) !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, grp);
        end
    endtask

    task automatic cmp_val(input string what, input logic [15:0] exp,
                           input logic [15:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic pulse_src(input string what, input int idx,
                             input logic [22:0] exp, input logic [22:0] care);
        host.set_src(idx, 1'b1);
        wait_cyc(SETTLE);
        cmp_grp(what, exp, care);
        host.set_src(idx, 1'b0);
        wait_cyc(SETTLE);
        cmp_grp("idle", 23'h00_0000, 23'h7f_ffff);
    endtask

    task automatic t_pg_fields();
        host.nvm_load(16'h5a3c);
        wait_cyc(SETTLE);
        cmp_val("pg fields", 16'h5a3c, pg_fields_ff);
        for (int i = `RDD_SRC_PIN; i < `RDD_SRC_DEV_SW; i++)
        begin
            host.set_src(i, 1'b1);
            wait_cyc(SETTLE);
            host.set_src(i, 1'b0);
        end
        wait_cyc(SETTLE);
        cmp_val("pg fields kept", 16'h5a3c, pg_fields_ff);
        host.set_src(`RDD_SRC_PWR_GOOD, 1'b1);
        wait_cyc(SETTLE);
        cmp_val("pg fields clr", `RDD_PG_FIELD_RST, pg_fields_ff);
        host.set_src(`RDD_SRC_PWR_GOOD, 1'b0);
        wait_cyc(SETTLE);
        host.nvm_load(16'hc3a5);
        wait_cyc(SETTLE);
        cmp_val("pg fields reload", 16'hc3a5, pg_fields_ff);
    endtask

    task automatic t_common();
        pulse_src("power good", `RDD_SRC_PWR_GOOD,
                  23'h7f_fbfe, 23'h7f_fbfe);
        pulse_src("pcie pin", `RDD_SRC_PIN,
                  23'h7f_f878, 23'h7f_fafe);
        pulse_src("inband", `RDD_SRC_INBAND,
                  23'h6f_db00, 23'h7f_dbfe);
        pulse_src("firmware", `RDD_SRC_FW,
                  23'h00_0020, 23'h7f_fbfe);
    endtask

    task automatic t_function();
        pulse_src("d3hot d0", `RDD_SRC_D3D0,
                  23'h03_dc21, 23'h67_ffff);
        pulse_src("flr", `RDD_SRC_FLR,
                  23'h03_dc21, 23'h67_ffff);
        pulse_src("port sw", `RDD_SRC_PORT_SW,
                  23'h03_9821, 23'h7f_ffff);
        host.set_src(`RDD_SRC_FLR, 1'b1);
        host.set_src(`RDD_SRC_PORT_SW, 1'b1);
        wait_cyc(SETTLE);
        cmp_grp("flr and port", 23'h03_dc21, 23'h67_ffff);
        host.set_src(`RDD_SRC_FLR, 1'b0);
        wait_cyc(SETTLE);
        cmp_grp("port after flr", 23'h03_9821, 23'h7f_ffff);
        host.set_src(`RDD_SRC_PORT_SW, 1'b0);
        wait_cyc(SETTLE);
        cmp_grp("idle", 23'h00_0000, 23'h7f_ffff);
    endtask

    task automatic t_tx_blank();
        int hi;
        hi = 0;
        host.set_tx(8'ha5);
        wait_cyc(SETTLE);
        cmp_val("tx data", 16'h00a5, {8'h00, tx_data_out});
        host.set_src(`RDD_SRC_PORT_SW, 1'b1);
        wait_cyc(SETTLE);
        cmp_val("tx port sw", 16'h0000, {8'h00, tx_data_out});
        host.set_src(`RDD_SRC_PORT_SW, 1'b0);
        host.set_src(`RDD_SRC_DEV_SW, 1'b1);
        repeat (30)
        begin
            @(negedge sys_clk);
            if (nvm_func_reload_ff === 1'b1)
                hi++;
        end
        cmp_val("reload length", 16'(`RDD_NVM_LOAD_CYC), hi[15:0]);
        cmp_val("tx dev sw", 16'h0000, {8'h00, tx_data_out});
        cmp_grp("dev sw", 23'h00_2000, 23'h00_2000);
        host.set_src(`RDD_SRC_DEV_SW, 1'b0);
        wait_cyc(SETTLE);
        cmp_val("tx after", 16'h00a5, {8'h00, tx_data_out});
    endtask

    task automatic t_aux_off();
        host.set_aux(1'b0);
        pulse_src("pin no aux", `RDD_SRC_PIN,
                  23'h7f_fa78, 23'h7f_fafe);
        cmp_val("wake bits", 16'h0000, {12'h000, pme_enable_ff,
                pme_status_ff, wake_shadow_pme_en_ff,
                wake_shadow_pme_st_ff});
        host.set_aux(1'b1);
    endtask

    initial
    begin
        repeat (2) @(negedge sys_clk);
        cmp_grp("in reset", 23'h7f_ffff, 23'h7f_ffff);
        reset = 1'b0;
        wait_cyc(SETTLE);
        cmp_grp("idle", 23'h00_0000, 23'h7f_ffff);
        t_pg_fields();
        t_common();
        t_function();
        t_tx_blank();
        t_aux_off();
        close_out();
    end
endmodule
`default_nettype wire
